// File: pkg/opcode_decode_cfg.svh
// Constants for the opcode decoder and operand-address generator
// Behaviour
// - Upper opcode nibble selects instruction group
// - Bit ops: even set, odd clear, bits 3:1
// - Branch nibble selects one of sixteen conditions
// - Read-modify-write nibble selects operation; five unused
// - RMW upper nibble gives mode; 0x42 multiply
// - Control group decodes thirteen fixed opcodes
// - Register/memory groups: six modes, sixteen operations
// - 0xAD relative call; 0xA7, 0xAC unimplemented
// - Ten addressing modes supported
// - Operand location; lengths one to three bytes
// - Implied mode: no operands, advance one
// - Literal operand at PC+1, advance two
// - Direct: high byte zero, advance two
// - Full address from two bytes, advance three
// - Plain index: zero-extended index, advance one
// - Byte offset plus index with carry, advance two
// - Word offset plus index, advance three
// - Branch adds offset to PC+2 if true
// - Bit branch: testedBit output gives bit, PC+3 target
`ifndef OPCODE_DECODE_CFG_SVH
`define OPCODE_DECODE_CFG_SVH
`define GRP_BIT_BRANCH 4'h0
`define GRP_BIT_SETCLR 4'h1
`define GRP_PC_BRANCH  4'h2
`define GRP_RMW_FIRST  4'h3
`define GRP_RMW_LAST   4'h7
`define GRP_CTRL_FIRST 4'h8
`define GRP_CTRL_LAST  4'h9
`define GRP_REGMEM_FIRST 4'hA
`define OPC_MULTIPLY   8'h42
`define OPC_PC_CALL    8'hAD
`define OPC_LIT_STORE  8'hA7
`define OPC_LIT_JUMP   8'hAC
`define LEN_ONE        2'h1
`define LEN_TWO        2'h2
`define LEN_THREE      2'h3
`endif

// File: pkg/opcode_decode_pkg.sv
// Types for the opcode decoder
package opcode_decode_pkg;
   typedef enum logic [2:0] {
      GROUP_BIT_BRANCH = 3'h0,
      GROUP_BIT_SETCLR = 3'h1,
      GROUP_PC_BRANCH  = 3'h2,
      GROUP_RMW        = 3'h3,
      GROUP_CONTROL    = 3'h4,
      GROUP_REGMEM     = 3'h5
   } group_t;

   typedef enum logic [3:0] {
      implied_mode           = 4'h0,
      literal_operand_mode   = 4'h1,
      direct_mode            = 4'h2,
      full_address_mode      = 4'h3,
      index_plain_mode       = 4'h4,
      index_byte_offset_mode = 4'h5,
      index_word_offset_mode = 4'h6,
      pc_relative_mode       = 4'h7,
      bit_set_clear_mode     = 4'h8,
      bit_test_branch_mode   = 4'h9
   } mode_t;

   // Operation codes, shared by all groups
   typedef enum logic [5:0] {
      OP_NONE = 6'h00,
      // Bit groups
      branch_if_bit_high = 6'h01, branch_if_bit_low = 6'h02,
      set_memory_bit = 6'h03, clear_memory_bit = 6'h04,
      // Branches
      OP_BR_ALWAYS = 6'h05, OP_BR_NEVER = 6'h06, OP_BR_HIGHER = 6'h07,
      OP_BR_LOWER_SAME = 6'h08, OP_BR_CARRY_CLEAR = 6'h09,
      OP_BR_CARRY_SET = 6'h0A, OP_BR_NOT_EQUAL = 6'h0B, OP_BR_EQUAL = 6'h0C,
      branch_half_carry_clear = 6'h0D, branch_half_carry_set = 6'h0E,
      OP_BR_PLUS = 6'h0F, OP_BR_MINUS = 6'h10, branch_mask_clear = 6'h11,
      branch_mask_set = 6'h12, branch_irq_pin_low = 6'h13,
      branch_irq_pin_high = 6'h14,
      // Read-modify-write
      OP_NEGATE = 6'h15, OP_COMPLEMENT = 6'h16, OP_SHIFT_RIGHT = 6'h17,
      OP_ROTATE_RIGHT = 6'h18, OP_ARITH_RIGHT = 6'h19, OP_SHIFT_LEFT = 6'h1A,
      OP_ROTATE_LEFT = 6'h1B, OP_DECREMENT = 6'h1C, OP_INCREMENT = 6'h1D,
      OP_TEST = 6'h1E, OP_CLEAR = 6'h1F, unsigned_multiply = 6'h20,
      // Control
      return_from_trap = 6'h21, OP_RETURN_SUB = 6'h22, software_trap = 6'h23,
      OP_STOP = 6'h24, OP_WAIT = 6'h25, copy_acc_to_index = 6'h26,
      OP_CLEAR_CARRY = 6'h27, OP_SET_CARRY = 6'h28, OP_CLEAR_MASK = 6'h29,
      OP_SET_MASK = 6'h2A, stack_pointer_reinit = 6'h2B, OP_NO_OP = 6'h2C,
      copy_index_to_acc = 6'h2D,
      // Register/memory
      OP_SUBTRACT = 6'h2E, OP_COMPARE_ACC = 6'h2F, OP_SUB_CARRY = 6'h30,
      OP_COMPARE_INDEX = 6'h31, OP_AND = 6'h32, OP_BIT_TEST = 6'h33,
      OP_LOAD_ACC = 6'h34, OP_STORE_ACC = 6'h35, OP_XOR = 6'h36,
      OP_ADD_CARRY = 6'h37, OP_OR = 6'h38, OP_ADD = 6'h39, OP_JUMP = 6'h3A,
      absolute_call = 6'h3B, OP_LOAD_INDEX = 6'h3C, OP_STORE_INDEX = 6'h3D,
      relative_call = 6'h3E
   } operation_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic       loaded;
   } state_t;
endpackage

// File: rtl/opcode_decode.sv
// Opcode decoder and operand-address generator
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decode_cfg.svh"
module opcode_decode (
   input  wire logic                          clock,
   input  wire logic                          reset,
   input  wire logic [7:0]                    opcodeIn,
   input  wire logic                          opcodeStrobe,
   input  wire logic [15:0]                   pcIn,
   input  wire logic [7:0]                    operandByte1,
   input  wire logic [7:0]                    operandByte2,
   input  wire logic [7:0]                    indexReg,
   input  wire logic                          conditionTrue,
   input  wire logic [7:0]                    testedByte,
   output logic                               decodeValid,
   output opcode_decode_pkg::group_t          group,
   output opcode_decode_pkg::operation_t      operation,
   output opcode_decode_pkg::mode_t           addrMode,
   output logic [1:0]                         instrLength,
   output logic [2:0]                         bitNumber,
   output logic [15:0]                        operand_location,
   output logic [15:0]                        nextPc,
   output logic                               testedBit,
   output logic                               opcodeHeld
);
   import opcode_decode_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Decoding functions

   function automatic operation_t branchOp(input logic [3:0] n);
      operation_t o;
      o = OP_NONE;
      case (n)
         4'h0: o = OP_BR_ALWAYS;
         4'h1: o = OP_BR_NEVER;
         4'h2: o = OP_BR_HIGHER;
         4'h3: o = OP_BR_LOWER_SAME;
         4'h4: o = OP_BR_CARRY_CLEAR;
         4'h5: o = OP_BR_CARRY_SET;
         4'h6: o = OP_BR_NOT_EQUAL;
         4'h7: o = OP_BR_EQUAL;
         4'h8: o = branch_half_carry_clear;
         4'h9: o = branch_half_carry_set;
         4'hA: o = OP_BR_PLUS;
         4'hB: o = OP_BR_MINUS;
         4'hC: o = branch_mask_clear;
         4'hD: o = branch_mask_set;
         4'hE: o = branch_irq_pin_low;
         4'hF: o = branch_irq_pin_high;
         default: o = OP_NONE;
      endcase
      return o;
   endfunction

   function automatic operation_t rmwOp(input logic [3:0] n);
      operation_t o;
      o = OP_NONE;
      case (n)
         4'h0: o = OP_NEGATE;
         4'h3: o = OP_COMPLEMENT;
         4'h4: o = OP_SHIFT_RIGHT;
         4'h6: o = OP_ROTATE_RIGHT;
         4'h7: o = OP_ARITH_RIGHT;
         4'h8: o = OP_SHIFT_LEFT;
         4'h9: o = OP_ROTATE_LEFT;
         4'hA: o = OP_DECREMENT;
         4'hC: o = OP_INCREMENT;
         4'hD: o = OP_TEST;
         4'hF: o = OP_CLEAR;
         default: o = OP_NONE;
      endcase
      return o;
   endfunction

   function automatic operation_t controlOp(input logic [7:0] c);
      operation_t o;
      o = OP_NONE;
      case (c)
         8'h80: o = return_from_trap;
         8'h81: o = OP_RETURN_SUB;
         8'h83: o = software_trap;
         8'h8E: o = OP_STOP;
         8'h8F: o = OP_WAIT;
         8'h97: o = copy_acc_to_index;
         8'h98: o = OP_CLEAR_CARRY;
         8'h99: o = OP_SET_CARRY;
         8'h9A: o = OP_CLEAR_MASK;
         8'h9B: o = OP_SET_MASK;
         8'h9C: o = stack_pointer_reinit;
         8'h9D: o = OP_NO_OP;
         8'h9F: o = copy_index_to_acc;
         default: o = OP_NONE;
      endcase
      return o;
   endfunction

   function automatic operation_t regMemOp(input logic [3:0] n);
      operation_t o;
      o = OP_NONE;
      case (n)
         4'h0: o = OP_SUBTRACT;
         4'h1: o = OP_COMPARE_ACC;
         4'h2: o = OP_SUB_CARRY;
         4'h3: o = OP_COMPARE_INDEX;
         4'h4: o = OP_AND;
         4'h5: o = OP_BIT_TEST;
         4'h6: o = OP_LOAD_ACC;
         4'h7: o = OP_STORE_ACC;
         4'h8: o = OP_XOR;
         4'h9: o = OP_ADD_CARRY;
         4'hA: o = OP_OR;
         4'hB: o = OP_ADD;
         4'hC: o = OP_JUMP;
         4'hD: o = absolute_call;
         4'hE: o = OP_LOAD_INDEX;
         4'hF: o = OP_STORE_INDEX;
         default: o = OP_NONE;
      endcase
      return o;
   endfunction

   function automatic logic [1:0] modeLength(input mode_t m);
      logic [1:0] l;
      l = `LEN_ONE;
      case (m)
         implied_mode:           l = `LEN_ONE;
         index_plain_mode:       l = `LEN_ONE;
         literal_operand_mode:   l = `LEN_TWO;
         direct_mode:            l = `LEN_TWO;
         index_byte_offset_mode: l = `LEN_TWO;
         pc_relative_mode:       l = `LEN_TWO;
         bit_set_clear_mode:     l = `LEN_TWO;
         full_address_mode:      l = `LEN_THREE;
         index_word_offset_mode: l = `LEN_THREE;
         bit_test_branch_mode:   l = `LEN_THREE;
         default:                l = `LEN_ONE;
      endcase
      return l;
   endfunction

   // Sign-extend a branch offset to address width
   function automatic logic [15:0] signExtend(input logic [7:0] b);
      logic [15:0] w;
      w = {{8{b[7]}}, b};
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Classification, combinational on the opcode

   logic [3:0]  hi;
   logic [3:0]  lo;
   logic [15:0] target;
   logic [15:0] bitTarget;
   logic [15:0] fallThrough;
   logic        taken;
   state_t      state_q;
   state_t      state_d;

   assign hi = opcodeIn[7:4];
   assign lo = opcodeIn[3:0];

   always_comb begin
      decodeValid = 1'b1;
      group       = GROUP_CONTROL;
      operation   = OP_NONE;
      addrMode    = implied_mode;
      bitNumber   = lo[3:1];
      if (hi == `GRP_BIT_BRANCH) begin
         group     = GROUP_BIT_BRANCH;
         addrMode  = bit_test_branch_mode;
         operation = lo[0] ? branch_if_bit_low : branch_if_bit_high;
      end else if (hi == `GRP_BIT_SETCLR) begin
         group     = GROUP_BIT_SETCLR;
         addrMode  = bit_set_clear_mode;
         operation = lo[0] ? clear_memory_bit : set_memory_bit;
      end else if (hi == `GRP_PC_BRANCH) begin
         group     = GROUP_PC_BRANCH;
         addrMode  = pc_relative_mode;
         operation = branchOp(lo);
      end else if (hi >= `GRP_RMW_FIRST && hi <= `GRP_RMW_LAST) begin
         group     = GROUP_RMW;
         operation = rmwOp(lo);
         case (hi)
            4'h3: addrMode = direct_mode;
            4'h4: addrMode = implied_mode;
            4'h5: addrMode = implied_mode;
            4'h6: addrMode = index_byte_offset_mode;
            4'h7: addrMode = index_plain_mode;
            default: addrMode = implied_mode;
         endcase
         if (opcodeIn == `OPC_MULTIPLY) begin
            operation = unsigned_multiply;
         end
      end else if (hi >= `GRP_CTRL_FIRST && hi <= `GRP_CTRL_LAST) begin
         group     = GROUP_CONTROL;
         addrMode  = implied_mode;
         operation = controlOp(opcodeIn);
      end else begin
         group     = GROUP_REGMEM;
         operation = regMemOp(lo);
         case (hi)
            4'hA: addrMode = literal_operand_mode;
            4'hB: addrMode = direct_mode;
            4'hC: addrMode = full_address_mode;
            4'hD: addrMode = index_word_offset_mode;
            4'hE: addrMode = index_byte_offset_mode;
            4'hF: addrMode = index_plain_mode;
            default: addrMode = implied_mode;
         endcase
         if (opcodeIn == `OPC_PC_CALL) begin
            operation = relative_call;
            addrMode  = pc_relative_mode;
         end
         if (opcodeIn == `OPC_LIT_STORE || opcodeIn == `OPC_LIT_JUMP) begin
            operation = OP_NONE;
         end
      end
      if (operation == OP_NONE) begin
         decodeValid = 1'b0;
      end
      instrLength = modeLength(addrMode);
   end

   ////////////////////////////////////////////////////////////////////
   // Operand location and next program counter

   assign testedBit   = testedByte[bitNumber];
   assign fallThrough = pcIn + {14'h0000, instrLength};
   assign target      = fallThrough + signExtend(operandByte1);
   assign bitTarget   = fallThrough + signExtend(operandByte2);

   // Bit 0 clear branches on a set bit; calls always go
   always_comb begin
      taken = 1'b0;
      case (addrMode)
         bit_test_branch_mode: begin
            taken = testedBit ^ lo[0];
         end
         pc_relative_mode: begin
            if (operation == relative_call) begin
               taken = 1'b1;
            end else begin
               taken = conditionTrue;
            end
         end
         default: taken = 1'b0;
      endcase
   end

   always_comb begin
      operand_location = 16'h0000;
      nextPc           = fallThrough;
      case (addrMode)
         literal_operand_mode:   operand_location = pcIn + 16'h0001;
         direct_mode:            operand_location = {8'h00, operandByte1};
         bit_set_clear_mode:     operand_location = {8'h00, operandByte1};
         full_address_mode:      operand_location = {operandByte1, operandByte2};
         index_plain_mode:       operand_location = {8'h00, indexReg};
         // Carry of the sum lands in the high byte
         index_byte_offset_mode:
            operand_location = {8'h00, indexReg} + {8'h00, operandByte1};
         index_word_offset_mode:
            operand_location = {operandByte1, operandByte2} + {8'h00, indexReg};
         pc_relative_mode: begin
            operand_location = taken ? target : fallThrough;
            nextPc           = operand_location;
         end
         bit_test_branch_mode: begin
            operand_location = {8'h00, operandByte1};
            nextPc           = taken ? bitTarget : fallThrough;
         end
         default: operand_location = 16'h0000;
      endcase
      if (!decodeValid) begin
         nextPc = pcIn;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Last accepted opcode, observation only

   always_comb begin
      state_d = state_q;
      // Only implemented opcodes are latched
      if (opcodeStrobe && decodeValid) begin
         state_d.opcode = opcodeIn;
         state_d.loaded = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign opcodeHeld = state_q.loaded;
endmodule
`default_nettype wire

// File: bench/fetch_model.sv
// Program memory model standing on the fetch side of the decoder
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
   input  wire logic [15:0] pc,
   output logic      [7:0]  opcode,
   output logic      [7:0]  byte1,
   output logic      [7:0]  byte2
);
   logic [7:0] mem [256];
   initial for (int i = 0; i < 256; i++) mem[i] = 8'h9D;
   // Opcode and the two bytes after it, wrapping in one page
   assign opcode = mem[pc[7:0]];
   assign byte1  = mem[8'(pc[7:0] + 8'h01)];
   assign byte2  = mem[8'(pc[7:0] + 8'h02)];
endmodule
`default_nettype wire

// File: bench/opcode_decode_asserts.sv
// Port-level checker for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_asserts
   import opcode_decode_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [7:0]  opcodeIn,
   input wire logic        opcodeStrobe,
   input wire logic [15:0] pcIn,
   input wire logic [7:0]  operandByte1,
   input wire logic [7:0]  operandByte2,
   input wire logic [7:0]  indexReg,
   input wire logic        conditionTrue,
   input wire logic [7:0]  testedByte,
   input wire logic        decodeValid,
   input wire group_t      group,
   input wire operation_t  operation,
   input wire mode_t       addrMode,
   input wire logic [1:0]  instrLength,
   input wire logic [2:0]  bitNumber,
   input wire logic [15:0] operand_location,
   input wire logic [15:0] nextPc,
   input wire logic        testedBit,
   input wire logic        opcodeHeld
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [15:0] sx1;
   logic [15:0] sx2;
   assign sx1 = {{8{operandByte1[7]}}, operandByte1};
   assign sx2 = {{8{operandByte2[7]}}, operandByte2};
   sequence s_strobed_valid;
      opcodeStrobe && decodeValid;
   endsequence
   sequence s_held_now;
      opcodeHeld;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_group_branch: assert property (opcodeIn[7:4] == 4'h2 |-> group == GROUP_PC_BRANCH)
      else $error("branch group wrong");
   a_bit_field: assert property (opcodeIn[7:5] == 3'h0 |-> bitNumber == opcodeIn[3:1]
      && testedBit == testedByte[opcodeIn[3:1]]) else $error("bit field wrong");
   a_invalid_none: assert property (!decodeValid |-> operation == OP_NONE
      && nextPc == pcIn) else $error("invalid opcode has effect");
   a_implied_len: assert property (decodeValid && addrMode == implied_mode
      |-> instrLength == 2'h1 && nextPc == pcIn + 16'h1) else $error("implied length wrong");
   a_direct_page: assert property (addrMode == direct_mode
      |-> operand_location == {8'h00, operandByte1}) else $error("direct address wrong");
   a_full_addr: assert property (addrMode == full_address_mode
      |-> operand_location == {operandByte1, operandByte2}) else $error("full address wrong");
   a_index_plain: assert property (addrMode == index_plain_mode
      |-> operand_location == {8'h00, indexReg}) else $error("plain index wrong");
   a_byte_offset: assert property (addrMode == index_byte_offset_mode
      |-> operand_location == 16'(indexReg) + 16'(operandByte1)) else $error("byte offset wrong");
   a_word_offset: assert property (addrMode == index_word_offset_mode
      |-> operand_location == {operandByte1, operandByte2} + 16'(indexReg))
      else $error("word offset wrong");
   a_branch_target: assert property (decodeValid && group == GROUP_PC_BRANCH
      |-> nextPc == pcIn + 16'h2 + (conditionTrue ? sx1 : 16'h0)) else $error("branch target");
   a_call_taken: assert property (operation == relative_call
      |-> nextPc == pcIn + 16'h2 + sx1) else $error("relative call target");
   a_bit_branch: assert property (group == GROUP_BIT_BRANCH
      |-> nextPc == pcIn + 16'h3 + ((testedBit ^ opcodeIn[0]) ? sx2 : 16'h0))
      else $error("bit branch target");
   a_held_sets: assert property (s_strobed_valid |=> s_held_now)
      else $error("held flag not set");
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import opcode_decode_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        opcodeStrobe = 1'b0;
   logic        conditionTrue = 1'b0;
   logic [15:0] pcIn = 16'h0000;
   logic [7:0]  indexReg = 8'h00;
   logic [7:0]  testedByte = 8'h00;
   logic [7:0]  opcodeIn, operandByte1, operandByte2;
   logic        decodeValid, testedBit, opcodeHeld;
   group_t      group;
   operation_t  operation;
   mode_t       addrMode;
   logic [1:0]  instrLength;
   logic [2:0]  bitNumber;
   logic [15:0] operand_location, nextPc;
   int          bad_count = 0;
   int          checked = 0;
   localparam operation_t rmwOps [16] = '{OP_NEGATE, OP_NONE, OP_NONE, OP_COMPLEMENT,
      OP_SHIFT_RIGHT, OP_NONE, OP_ROTATE_RIGHT, OP_ARITH_RIGHT, OP_SHIFT_LEFT, OP_ROTATE_LEFT,
      OP_DECREMENT, OP_NONE, OP_INCREMENT, OP_TEST, OP_NONE, OP_CLEAR};
   localparam mode_t rmwMode [5] = '{direct_mode, implied_mode, implied_mode,
      index_byte_offset_mode, index_plain_mode};
   localparam mode_t rmMode [6] = '{literal_operand_mode, direct_mode, full_address_mode,
      index_word_offset_mode, index_byte_offset_mode, index_plain_mode};
   localparam logic [15:0] rmLoc [6] = '{16'h2001, 16'h0012, 16'h12F0, 16'h13E0,
      16'h0102, 16'h00F0};
   localparam logic [1:0] rmLen [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
   localparam logic [7:0] ctlOp [13] = '{8'h80, 8'h81, 8'h83, 8'h8E, 8'h8F, 8'h97, 8'h98,
      8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9F};
   fetch_model u_fetch_model (.pc(pcIn), .opcode(opcodeIn), .byte1(operandByte1),
      .byte2(operandByte2));
   opcode_decode u_opcode_decode (.clock(clock), .reset(reset), .opcodeIn(opcodeIn),
      .opcodeStrobe(opcodeStrobe), .pcIn(pcIn), .operandByte1(operandByte1),
      .operandByte2(operandByte2), .indexReg(indexReg), .conditionTrue(conditionTrue),
      .testedByte(testedByte), .decodeValid(decodeValid), .group(group),
      .operation(operation), .addrMode(addrMode), .instrLength(instrLength),
      .bitNumber(bitNumber), .operand_location(operand_location), .nextPc(nextPc),
      .testedBit(testedBit), .opcodeHeld(opcodeHeld));
   initial forever #2 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic load(input logic [15:0] p, input logic [7:0] op, b1, b2, x, tb,
                       input logic c);
      @(posedge clock);
      pcIn <= p;
      indexReg <= x;
      testedByte <= tb;
      conditionTrue <= c;
      u_fetch_model.mem[p[7:0]] <= op;
      u_fetch_model.mem[8'(p[7:0] + 8'h01)] <= b1;
      u_fetch_model.mem[8'(p[7:0] + 8'h02)] <= b2;
      #1;
   endtask
   task automatic t_groups;
      for (int n = 0; n < 16; n++) begin
         load(16'h0040, (n == 9) ? 8'h9D : {n[3:0], 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
         cmp("group", 16'((n < 3) ? n : (n < 8) ? 3 : (n < 10) ? 4 : 5), 16'(group));
      end
      $display("t_groups done");
   endtask
   task automatic t_branch;
      logic c;
      for (int n = 0; n < 16; n++) begin
         c = (n == 0) ? 1'b1 : (n == 1) ? 1'b0 : n[1];
         load(16'h10F0, {4'h2, n[3:0]}, 8'h85, 8'h00, 8'h00, 8'h00, c);
         cmp("operation", 16'(OP_BR_ALWAYS + n), 16'(operation));
         cmp("mode", 16'(pc_relative_mode), 16'(addrMode));
         cmp("nextPc", c ? 16'h10F2 + 16'hFF85 : 16'h10F2, nextPc);
      end
      $display("t_branch done");
   endtask
   task automatic t_rmw;
      logic [7:0]  op;
      logic        ok;
      logic [15:0] expOp;
      logic [15:0] expMode;
      for (int h = 3; h < 8; h++) begin
         for (int n = 0; n < 16; n++) begin
            op = {h[3:0], n[3:0]};
            load(16'h2000, op, 8'h12, 8'hF0, 8'hF0, 8'h00, 1'b0);
            ok = (op == 8'h42) || (rmwOps[n] != OP_NONE);
            expOp = (op == 8'h42) ? 16'(unsigned_multiply) : 16'(rmwOps[n]);
            expMode = (op == 8'h42) ? 16'(implied_mode) : 16'(rmwMode[h - 3]);
            cmp("valid", 16'(ok), 16'(decodeValid));
            cmp("operation", expOp, 16'(operation));
            if (ok) cmp("mode", expMode, 16'(addrMode));
         end
      end
      $display("t_rmw done");
   endtask
   task automatic t_control;
      int          j;
      logic [15:0] expOp;
      for (int k = 0; k < 32; k++) begin
         j = -1;
         for (int i = 0; i < 13; i++) if (ctlOp[i] == 8'(8'h80 + k)) j = i;
         load(16'h2000, 8'(8'h80 + k), 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
         expOp = (j < 0) ? 16'(OP_NONE) : 16'(return_from_trap + j);
         cmp("operation", expOp, 16'(operation));
         cmp("valid", 16'(j >= 0), 16'(decodeValid));
         if (j >= 0) cmp("nextPc", 16'h2001, nextPc);
         if (j >= 0) cmp("length", 16'h1, 16'(instrLength));
      end
      $display("t_control done");
   endtask
   task automatic t_regmem;
      logic [7:0] op;
      for (int h = 10; h < 16; h++) begin
         for (int n = 0; n < 16; n++) begin
            op = {h[3:0], n[3:0]};
            if (op != 8'hA7 && op != 8'hAC && op != 8'hAD) begin
               load(16'h2000, op, 8'h12, 8'hF0, 8'hF0, 8'h00, 1'b0);
               cmp("operation", 16'(OP_SUBTRACT + n), 16'(operation));
               cmp("mode", 16'(rmMode[h - 10]), 16'(addrMode));
               cmp("length", 16'(rmLen[h - 10]), 16'(instrLength));
               cmp("location", rmLoc[h - 10], operand_location);
               if (n != 12 && n != 13)
                  cmp("nextPc", 16'h2000 + 16'(rmLen[h - 10]), nextPc);
            end
         end
      end
      load(16'h2000, 8'hA7, 8'h12, 8'hF0, 8'hF0, 8'h00, 1'b0);
      cmp("valid", 16'h0, 16'(decodeValid));
      load(16'h2000, 8'hAC, 8'h12, 8'hF0, 8'hF0, 8'h00, 1'b0);
      cmp("valid", 16'h0, 16'(decodeValid));
      load(16'h2000, 8'hAD, 8'h80, 8'hF0, 8'hF0, 8'h00, 1'b0);
      cmp("operation", 16'(relative_call), 16'(operation));
      cmp("nextPc", 16'h1F82, nextPc);
      $display("t_regmem done");
   endtask
   task automatic t_bits;
      logic [7:0] op;
      logic        bt;
      logic [7:0]  tv;
      logic [15:0] expOp;
      logic [15:0] expMode;
      tv = 8'hA5;
      for (int g = 0; g < 2; g++) begin
         for (int n = 0; n < 16; n++) begin
            op = {3'h0, g[0], n[3:0]};
            bt = tv[n[3:1]];
            load(16'h3000, op, 8'h44, 8'hFA, 8'h00, tv, 1'b0);
            cmp("bitNumber", 16'(n[3:1]), 16'(bitNumber));
            cmp("testedBit", 16'(bt), 16'(testedBit));
            cmp("location", 16'h0044, operand_location);
            expOp = n[0] ? 16'(branch_if_bit_low) : 16'(branch_if_bit_high);
            if (g) expOp = n[0] ? 16'(clear_memory_bit) : 16'(set_memory_bit);
            expMode = g ? 16'(bit_set_clear_mode) : 16'(bit_test_branch_mode);
            cmp("operation", expOp, 16'(operation));
            cmp("mode", expMode, 16'(addrMode));
            cmp("nextPc", g ? 16'h3002 : ((bt ^ n[0]) ? 16'h2FFD : 16'h3003), nextPc);
         end
      end
      $display("t_bits done");
   endtask
   task automatic t_held;
      load(16'h2000, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
      @(posedge clock) opcodeStrobe <= 1'b1;
      @(posedge clock) opcodeStrobe <= 1'b0;
      #1 cmp("opcodeHeld", 16'h0, 16'(opcodeHeld));
      load(16'h2000, 8'h9D, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
      @(posedge clock) opcodeStrobe <= 1'b1;
      @(posedge clock) opcodeStrobe <= 1'b0;
      #1 cmp("opcodeHeld", 16'h1, 16'(opcodeHeld));
      @(posedge clock) reset <= 1'b1;
      @(posedge clock) reset <= 1'b0;
      #1 cmp("opcodeHeld", 16'h0, 16'(opcodeHeld));
      $display("t_held done");
   endtask
   task automatic print_verdict;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      t_groups;
      t_branch;
      t_rmw;
      t_control;
      t_regmem;
      t_bits;
      t_held;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clock);
      bad_count++;
      print_verdict;
   end
endmodule
bind opcode_decode opcode_decode_asserts u_opcode_decode_asserts (.clock(clock), .reset(reset),
   .opcodeIn(opcodeIn), .opcodeStrobe(opcodeStrobe), .pcIn(pcIn),
   .operandByte1(operandByte1), .operandByte2(operandByte2), .indexReg(indexReg),
   .conditionTrue(conditionTrue), .testedByte(testedByte), .decodeValid(decodeValid),
   .group(group), .operation(operation), .addrMode(addrMode), .instrLength(instrLength),
   .bitNumber(bitNumber), .operand_location(operand_location), .nextPc(nextPc),
   .testedBit(testedBit), .opcodeHeld(opcodeHeld));
`default_nettype wire
